// ### rtl/drmsc_map.vh
/*
 Constants for the reference, monitor and serial control block.
 Assumes inclusion by bare name from the rtl folder.
*/
`ifndef DRMSC_MAP_VH
`define DRMSC_MAP_VH
// Reference source select codes
`define DRMSC_REF_EXT_1V25 2'h0
`define DRMSC_REF_EXT_2V5 2'h1
`define DRMSC_REF_INT_NOUT 2'h2
`define DRMSC_REF_INT_OUT 2'h3
`define DRMSC_REF_RST 2'h1
// Third switch positions
`define DRMSC_SW3_TO_SW2 1'h0
`define DRMSC_SW3_TO_DIV 1'h1
// Resistor select
`define DRMSC_RES_INT 1'h0
`define DRMSC_RES_EXT 1'h1
// Monitor function codes
`define DRMSC_MON_OFF 2'h0
`define DRMSC_MON_VOLT 2'h1
`define DRMSC_MON_CURR 2'h2
`define DRMSC_MON_TEMP 2'h3
// Register map reach
`define DRMSC_REG_ADDR_MAX 7'h7F
`define DRMSC_REG_REF 7'h1B
`define DRMSC_REG_MON 7'h1C
// Field positions
`define DRMSC_REF_SEL_LSB 0
`define DRMSC_RES_SEL_BIT 2
`define DRMSC_MONITOR_CHANNEL_SELECT_LSB 0
`define DRMSC_MON_FN_LSB 4
`define DRMSC_MON_BUF_BIT 3
`define DRMSC_MON_BIAS_BIT 6
// Serial framing
`define DRMSC_INSTR_BITS 8
`define DRMSC_DATA_BITS 8
`define DRMSC_CNT_W 4
`endif

// ### rtl/drmsc_sync.v
/*
 Two flip-flop synchroniser for one level.
 Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
module drmsc_sync #(
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Level
  input wire d,
  output wire q
);
  reg meta_reg;
  reg sync_reg;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end
  assign q = sync_reg;
endmodule // drmsc_sync

// ### rtl/drmsc_edge.v
/*
 Rising and falling edge detector on a synchronised level.
 Assumes the input is already in the clk domain.
*/
`timescale 1ns/1ps
module drmsc_edge #(
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Level and edges
  input wire d,
  output wire rise,
  output wire fall
);
  reg last_reg;
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      last_reg <= RST_VAL;
    else
      last_reg <= d;
  end
  assign rise = d & ~last_reg;
  assign fall = ~d & last_reg;
endmodule // drmsc_edge

// ### rtl/drmsc_ctrl.v
/*
 Reference, set resistor, monitor mux and SPI slave control.
 Assumes an SPI mode 0 master; pins are asynchronous to clk and
 SCLK runs well below a quarter of clk.
*/
// What this block does
// - Select external 1.25 V or 2.5 V reference; 2.5 V goes via divider.
// - Reference select resets to the external 2.5 V option.
// - Internal reference powered only while internal source selected.
// - Internal with pin output: first and second closed, third to second.
// - Internal without pin output: first open, second closed, third to 2.
// - External 1.25 V: first closed, second open, third to second.
// - External 2.5 V: first and second open, third to divider.
// - One select bit drives the resistor switch internal or external.
// - Resistor select resets to the internal resistor.
// - External resistor below minimum forces the internal resistor.
// - Monitoring off at reset; active only for nonzero function code.
// - Monitor buffer off and bypassed at reset; on when enable set.
// - Voltage monitoring routes the chosen channel's compliance voltage.
// - Current monitoring routes chosen channel current, valid when sourcing.
// - Temperature monitoring routes the die diode voltage.
// - External bias bit swaps internal diode bias for external current.
// - SPI mode 0; bits valid and sampled at rising SCLK.
// - All transfers are most significant bit first.
// - Each transaction is an instruction phase then a data phase.
// - After chip select falls, read/write flag then address arrive.
// - Flag 1 means read, flag 0 means write.
// - Seven-bit address is the start register for the data.
// - Chip select high before instruction ends aborts with no effect.
// - Reads shift register out on SDO; writes store received data.
`timescale 1ns/1ps
`include "drmsc_map.vh"
module drmsc_ctrl #(
  parameter NCH = 6,
  parameter CH_W = 3
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Serial pins
  input wire cs_n,
  input wire sclk,
  input wire sdi,
  output reg sdo,
  output reg sdo_oe_n,
  // Fault and channel status inputs
  input wire ext_res_low,
  input wire [NCH-1:0] ch_sourcing,
  // Reference control
  output reg [1:0] ref_source_select,
  output reg int_ref_enable,
  output reg first_reference_switch,
  output reg second_reference_switch,
  output reg third_reference_switch,
  // Set resistor control
  output reg resistor_select,
  output reg resistor_switch,
  // Monitor control
  output reg [1:0] monitor_function_select,
  output reg [CH_W-1:0] monitor_channel_select,
  output reg monitor_buffer_enable,
  output reg external_bias_enable,
  output reg [NCH-1:0] mon_volt_sel,
  output reg [NCH-1:0] mon_curr_sel,
  output reg mon_temp_sel,
  output reg mon_out_enable,
  output reg mon_curr_valid,
  // Access strobes for the wider register map
  output reg wr_stb,
  output reg rd_stb,
  output reg [6:0] acc_addr,
  output reg [7:0] wr_data,
  input wire [7:0] ext_rd_data
);
  localparam ST_IDLE = 4'h1;
  localparam ST_INSTR = 4'h2;
  localparam ST_DATA = 4'h4;
  localparam ST_WAIT = 4'h8;

  wire cs_s;
  wire sclk_s;
  wire sdi_s;
  wire res_low_s;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_rise;
  wire cs_fall;
  wire [NCH-1:0] src_s;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [`DRMSC_CNT_W-1:0] cnt_reg;
  reg [`DRMSC_CNT_W-1:0] cnt_next;
  reg [7:0] shift_reg;
  reg [7:0] shift_next;
  reg [7:0] tx_reg;
  reg [7:0] tx_next;
  reg read_reg;
  reg read_next;
  reg [6:0] addr_reg;
  reg [6:0] addr_next;
  reg [7:0] ref_cfg_reg;
  reg [7:0] mon_cfg_reg;
  reg [7:0] rd_val;

  drmsc_sync #(.RST_VAL(1'b1)) u_cs_sync (
    .clk(clk), .rstn(rstn), .d(cs_n), .q(cs_s));
  drmsc_sync #(.RST_VAL(1'b0)) u_sclk_sync (
    .clk(clk), .rstn(rstn), .d(sclk), .q(sclk_s));
  drmsc_sync #(.RST_VAL(1'b0)) u_sdi_sync (
    .clk(clk), .rstn(rstn), .d(sdi), .q(sdi_s));
  drmsc_sync #(.RST_VAL(1'b0)) u_res_sync (
    .clk(clk), .rstn(rstn), .d(ext_res_low), .q(res_low_s));
  drmsc_edge #(.RST_VAL(1'b0)) u_sclk_edge (
    .clk(clk), .rstn(rstn), .d(sclk_s), .rise(sclk_rise),
    .fall(sclk_fall));
  drmsc_edge #(.RST_VAL(1'b1)) u_cs_edge (
    .clk(clk), .rstn(rstn), .d(cs_s), .rise(cs_rise), .fall(cs_fall));

  // Channel sourcing status comes from the analog side
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_src_sync
      drmsc_sync #(.RST_VAL(1'b0)) u_src_sync (
        .clk(clk), .rstn(rstn), .d(ch_sourcing[gi]), .q(src_s[gi]));
    end
  endgenerate

  // Read value of addressed register
  always @* begin
    case (addr_reg)
      `DRMSC_REG_REF: rd_val = ref_cfg_reg;
      `DRMSC_REG_MON: rd_val = mon_cfg_reg;
      default: rd_val = ext_rd_data;
    endcase
  end

  // Serial state machine
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    read_next = read_reg;
    addr_next = addr_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cs_fall) begin
          state_next = ST_INSTR;
          cnt_next = {`DRMSC_CNT_W{1'b0}};
        end
      end
      ST_INSTR: begin
        if (cs_s) begin
          state_next = ST_IDLE;
        end else if (sclk_rise) begin
          shift_next = {shift_reg[6:0], sdi_s};
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg == `DRMSC_INSTR_BITS - 1) begin
            read_next = shift_reg[6];
            addr_next = {shift_reg[5:0], sdi_s};
            cnt_next = {`DRMSC_CNT_W{1'b0}};
            state_next = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (cs_s) begin
          state_next = ST_IDLE;
        end else if (sclk_fall) begin
          // First fall of data phase puts the MSB up for the next rise
          if (cnt_reg == {`DRMSC_CNT_W{1'b0}})
            tx_next = read_reg ? rd_val : 8'h00;
          else
            tx_next = {tx_reg[6:0], 1'b0};
        end else if (sclk_rise) begin
          shift_next = {shift_reg[6:0], sdi_s};
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg == `DRMSC_DATA_BITS - 1) begin
            cnt_next = {`DRMSC_CNT_W{1'b0}};
            state_next = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (cs_s)
          state_next = ST_IDLE;
        else if (sclk_fall)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    // Clear read word between frames
    if (state_reg == ST_INSTR && state_next == ST_DATA)
      tx_next = 8'h00;
    if (state_reg == ST_WAIT)
      tx_next = 8'h00;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= {`DRMSC_CNT_W{1'b0}};
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      read_reg <= 1'b0;
      addr_reg <= 7'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      read_reg <= read_next;
      addr_reg <= addr_next;
    end
  end

  // Register writes and access strobes
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_cfg_reg <= {5'h00, `DRMSC_RES_INT, `DRMSC_REF_RST};
      mon_cfg_reg <= 8'h00;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      acc_addr <= 7'h00;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (state_reg == ST_INSTR && state_next == ST_DATA) begin
        acc_addr <= addr_next;
        rd_stb <= read_next;
      end
      if (state_reg == ST_DATA && state_next == ST_WAIT && !read_reg) begin
        wr_stb <= 1'b1;
        wr_data <= shift_next;
        if (addr_reg == `DRMSC_REG_REF)
          ref_cfg_reg <= shift_next;
        if (addr_reg == `DRMSC_REG_MON)
          mon_cfg_reg <= shift_next;
      end
    end
  end

  // SDO drive, changes after falling SCLK
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sdo <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else begin
      sdo <= tx_reg[7];
      sdo_oe_n <= ~((state_reg == ST_DATA) & read_reg);
    end
  end

  // Reference, resistor and monitor decode
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_source_select <= `DRMSC_REF_RST;
      int_ref_enable <= 1'b0;
      first_reference_switch <= 1'b0;
      second_reference_switch <= 1'b0;
      third_reference_switch <= `DRMSC_SW3_TO_DIV;
      resistor_select <= `DRMSC_RES_INT;
      resistor_switch <= `DRMSC_RES_INT;
      monitor_function_select <= `DRMSC_MON_OFF;
      monitor_channel_select <= {CH_W{1'b0}};
      monitor_buffer_enable <= 1'b0;
      external_bias_enable <= 1'b0;
      mon_volt_sel <= {NCH{1'b0}};
      mon_curr_sel <= {NCH{1'b0}};
      mon_temp_sel <= 1'b0;
      mon_out_enable <= 1'b0;
      mon_curr_valid <= 1'b0;
    end else begin
      ref_source_select <= ref_cfg_reg[`DRMSC_REF_SEL_LSB+:2];
      int_ref_enable <= ref_cfg_reg[`DRMSC_REF_SEL_LSB+1];
      case (ref_cfg_reg[`DRMSC_REF_SEL_LSB+:2])
        `DRMSC_REF_INT_OUT: begin
          first_reference_switch <= 1'b1;
          second_reference_switch <= 1'b1;
          third_reference_switch <= `DRMSC_SW3_TO_SW2;
        end
        `DRMSC_REF_INT_NOUT: begin
          first_reference_switch <= 1'b0;
          second_reference_switch <= 1'b1;
          third_reference_switch <= `DRMSC_SW3_TO_SW2;
        end
        `DRMSC_REF_EXT_1V25: begin
          first_reference_switch <= 1'b1;
          second_reference_switch <= 1'b0;
          third_reference_switch <= `DRMSC_SW3_TO_SW2;
        end
        default: begin
          first_reference_switch <= 1'b0;
          second_reference_switch <= 1'b0;
          third_reference_switch <= `DRMSC_SW3_TO_DIV;
        end
      endcase
      resistor_select <= ref_cfg_reg[`DRMSC_RES_SEL_BIT];
      resistor_switch <= ref_cfg_reg[`DRMSC_RES_SEL_BIT] &
                         ~res_low_s;
      monitor_function_select <= mon_cfg_reg[`DRMSC_MON_FN_LSB+:2];
      monitor_channel_select <= mon_cfg_reg[`DRMSC_MONITOR_CHANNEL_SELECT_LSB+:CH_W];
      monitor_buffer_enable <= mon_cfg_reg[`DRMSC_MON_BUF_BIT];
      external_bias_enable <= mon_cfg_reg[`DRMSC_MON_BIAS_BIT];
      mon_out_enable <= mon_cfg_reg[`DRMSC_MON_FN_LSB+:2] !=
                        `DRMSC_MON_OFF;
      mon_volt_sel <= {NCH{1'b0}};
      mon_curr_sel <= {NCH{1'b0}};
      mon_temp_sel <= 1'b0;
      mon_curr_valid <= 1'b0;
      case (mon_cfg_reg[`DRMSC_MON_FN_LSB+:2])
        `DRMSC_MON_VOLT:
          mon_volt_sel <= {{(NCH-1){1'b0}}, 1'b1} <<
                          mon_cfg_reg[`DRMSC_MONITOR_CHANNEL_SELECT_LSB+:CH_W];
        `DRMSC_MON_CURR: begin
          mon_curr_sel <= {{(NCH-1){1'b0}}, 1'b1} <<
                          mon_cfg_reg[`DRMSC_MONITOR_CHANNEL_SELECT_LSB+:CH_W];
          mon_curr_valid <= src_s[mon_cfg_reg[`DRMSC_MONITOR_CHANNEL_SELECT_LSB+:CH_W]];
        end
        `DRMSC_MON_TEMP: mon_temp_sel <= 1'b1;
        default: mon_temp_sel <= 1'b0;
      endcase
    end
  end
endmodule // drmsc_ctrl

// ### tb/drmsc_ctrl_monitor.sv
/* Checker for the control block outputs.
 Bound to drmsc_ctrl; sees only its ports. */
`timescale 1ns/1ps
module drmsc_ctrl_monitor #(
  parameter NCH = 6,
  parameter CH_W = 3
) (
  // Clock, reset and pins
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic ext_res_low,
  input wire logic sdo_oe_n,
  // Reference and resistor
  input wire logic [1:0] ref_source_select,
  input wire logic int_ref_enable,
  input wire logic first_reference_switch,
  input wire logic second_reference_switch,
  input wire logic third_reference_switch,
  input wire logic resistor_select,
  input wire logic resistor_switch,
  // Monitor and strobes
  input wire logic [1:0] monitor_function_select,
  input wire logic [CH_W-1:0] monitor_channel_select,
  input wire logic [NCH-1:0] mon_volt_sel,
  input wire logic [NCH-1:0] mon_curr_sel,
  input wire logic mon_temp_sel,
  input wire logic mon_out_enable,
  input wire logic wr_stb,
  input wire logic rd_stb
);
  localparam [NCH-1:0] ONE = {{(NCH-1){1'b0}}, 1'b1};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_int_ref_on: assert property (
    int_ref_enable == ref_source_select[1]) else $error("ref enable");
  a_first_sw_pos: assert property (
    first_reference_switch == !(^ref_source_select))
    else $error("first switch");
  a_second_sw_pos: assert property (
    second_reference_switch == ref_source_select[1])
    else $error("second switch");
  a_third_sw_pos: assert property (
    third_reference_switch == (ref_source_select == 2'h1))
    else $error("third switch");
  a_res_forced: assert property ((resistor_select && ext_res_low)[*6]
    |-> !resistor_switch) else $error("fault override");
  a_res_ext: assert property ((resistor_select && !ext_res_low)[*6]
    |-> resistor_switch) else $error("external resistor");
  a_res_int: assert property ((!resistor_select)[*2] |->
    !resistor_switch) else $error("internal resistor");
  a_mon_off: assert property ((monitor_function_select == 2'h0)[*2]
    |-> !mon_out_enable && !mon_temp_sel && mon_volt_sel == 0 &&
    mon_curr_sel == 0) else $error("monitor not off");
  a_mon_volt: assert property ((monitor_function_select == 2'h1 &&
    $stable(monitor_channel_select))[*2] |->
    mon_volt_sel == ONE << monitor_channel_select) else $error("volt sel");
  a_mon_curr: assert property ((monitor_function_select == 2'h2 &&
    $stable(monitor_channel_select))[*2] |->
    mon_curr_sel == ONE << monitor_channel_select) else $error("curr sel");
  a_mon_temp: assert property ((monitor_function_select == 2'h3)[*2]
    |-> mon_temp_sel && mon_volt_sel == 0) else $error("temp sel");
  a_strobe_once: assert property (wr_stb || rd_stb |=>
    !wr_stb && !rd_stb) else $error("strobe too long");
  a_sdo_release: assert property (cs_n[*6] |-> sdo_oe_n)
    else $error("sdo driven while idle");
  c_int_pin: cover property (int_ref_enable && first_reference_switch);
  c_fault: cover property (resistor_select && !resistor_switch);
  c_temp: cover property (mon_temp_sel);
  c_read: cover property (rd_stb);
endmodule // drmsc_ctrl_monitor
bind drmsc_ctrl drmsc_ctrl_monitor #(.NCH(NCH), .CH_W(CH_W)) mon_i (
  .clk, .rstn, .cs_n, .ext_res_low, .sdo_oe_n, .ref_source_select,
  .int_ref_enable, .first_reference_switch, .second_reference_switch,
  .third_reference_switch, .resistor_select, .resistor_switch,
  .monitor_function_select, .monitor_channel_select, .mon_volt_sel,
  .mon_curr_sel, .mon_temp_sel, .mon_out_enable, .wr_stb, .rd_stb);

// ### tb/drmsc_spi_master.sv
/* Serial master model, mode 0, one frame per call.
 Assumes the block oversamples SCLK with its own clock. */
`timescale 1ns/1ps
module drmsc_spi_master #(
  parameter HALF = 24
) (
  // Serial pins
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Sends n bits of a frame, captures SDO
  task frame(input logic [15:0] bits, input int n, output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = bits[15-i];
      #HALF sclk = 1'b1;
      rd = {rd[6:0], sdo_oe_n ? 1'bz : sdo};
      #HALF sclk = 1'b0;
    end
    sdi = ~sdi;
    #HALF cs_n = 1'b1;
    #(2*HALF);
  endtask
endmodule // drmsc_spi_master

// ### tb/test_dac_ref_monitor_spi_ctrl.sv
/* Self-checking bench for the control block.
 Assumes a 250 MHz clock and the serial master model. */
`timescale 1ns/1ps
module test_dac_ref_monitor_spi_ctrl;
  logic clk, rstn, ext_res_low;
  logic [5:0] ch_sourcing;
  logic [7:0] ext_rd_data;
  wire cs_n, sclk, sdi, sdo, sdo_oe_n, int_ref_enable, resistor_select;
  wire first_reference_switch, second_reference_switch, resistor_switch;
  wire third_reference_switch, monitor_buffer_enable, mon_temp_sel;
  wire external_bias_enable, mon_out_enable, mon_curr_valid, wr_stb, rd_stb;
  wire [1:0] ref_source_select, monitor_function_select;
  wire [2:0] monitor_channel_select;
  wire [5:0] mon_volt_sel, mon_curr_sel;
  wire [6:0] acc_addr;
  wire [7:0] wr_data;
  int n_errors = 0, checked = 0, n_wr = 0, n_rd = 0, cyc = 0;
  drmsc_ctrl #(.NCH(6), .CH_W(3)) drmsc_ctrl_i (.clk, .rstn, .cs_n, .sclk,
    .sdi, .sdo, .sdo_oe_n, .ext_res_low, .ch_sourcing, .ref_source_select,
    .int_ref_enable, .first_reference_switch, .second_reference_switch,
    .third_reference_switch, .resistor_select, .resistor_switch,
    .monitor_function_select, .monitor_channel_select,
    .monitor_buffer_enable, .external_bias_enable, .mon_volt_sel,
    .mon_curr_sel, .mon_temp_sel, .mon_out_enable, .mon_curr_valid,
    .wr_stb, .rd_stb, .acc_addr, .wr_data, .ext_rd_data);
  drmsc_spi_master drmsc_spi_master_i (.cs_n, .sclk, .sdi, .sdo, .sdo_oe_n);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wr_stb === 1'b1) n_wr <= n_wr + 1;
    if (rd_stb === 1'b1) n_rd <= n_rd + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    drmsc_spi_master_i.frame({1'b0, a, d}, 16, r);
  endtask
  task t_reset;
    chk(ref_source_select, 8'h01);
    chk(int_ref_enable, 8'h00);
    chk({first_reference_switch, second_reference_switch,
      third_reference_switch}, 8'h01);
    chk({resistor_select, resistor_switch}, 8'h00);
    chk(monitor_function_select, 8'h00);
    chk({monitor_buffer_enable, mon_out_enable}, 8'h00);
  endtask
  task t_ref;
    logic [1:0] c;
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      wr(7'h1B, {6'h00, c});
      chk(ref_source_select, c);
      chk(int_ref_enable, c[1]);
      chk(first_reference_switch, !(^c));
      chk(second_reference_switch, c[1]);
      chk(third_reference_switch, c == 2'h1);
    end
  endtask
  task t_res;
    wr(7'h1B, 8'h06);
    chk({resistor_select, resistor_switch}, 8'h03);
    ext_res_low = 1'b1;
    idle(8);
    chk({resistor_select, resistor_switch}, 8'h02);
    ext_res_low = 1'b0;
    idle(8);
    chk(resistor_switch, 8'h01);
  endtask
  task t_abort;
    int w;
    logic [7:0] r;
    w = n_wr;
    drmsc_spi_master_i.frame(16'h1B00, 5, r);
    drmsc_spi_master_i.frame(16'h1B00, 12, r);
    chk(ref_source_select, 8'h02);
    chk(8'(n_wr - w), 8'h00);
  endtask
  task t_mon;
    wr(7'h1C, 8'h15);
    chk(mon_volt_sel, 8'h20);
    chk({mon_out_enable, monitor_channel_select}, 8'h0D);
    ch_sourcing = 6'h04;
    wr(7'h1C, 8'h22);
    chk(mon_curr_sel, 8'h04);
    chk({mon_curr_valid, mon_volt_sel}, 8'h40);
    ch_sourcing = 6'h3B;
    idle(8);
    chk(mon_curr_valid, 8'h00);
    wr(7'h1C, 8'h38);
    chk({mon_temp_sel, monitor_buffer_enable,
      external_bias_enable}, 8'h06);
    wr(7'h1C, 8'h70);
    chk({mon_temp_sel, monitor_buffer_enable,
      external_bias_enable}, 8'h05);
    wr(7'h1C, 8'h05);
    chk({mon_out_enable, mon_temp_sel, mon_volt_sel}, 8'h00);
    chk(monitor_function_select, 8'h00);
  endtask
  task t_other;
    int w, q;
    logic [7:0] r;
    w = n_wr;
    q = n_rd;
    wr(7'h40, 8'h3C);
    chk(acc_addr, 8'h40);
    chk(wr_data, 8'h3C);
    ext_rd_data = 8'h96;
    drmsc_spi_master_i.frame(16'hC100, 16, r);
    chk(r, 8'h96);
    chk(acc_addr, 8'h41);
    chk(8'(n_wr - w), 8'h01);
    chk(8'(n_rd - q), 8'h01);
    drmsc_spi_master_i.frame(16'h9C00, 16, r);
    chk(r, 8'h05);
  endtask
  initial begin
    rstn = 1'b0;
    ext_res_low = 1'b0;
    ch_sourcing = 6'h00;
    ext_rd_data = 8'h00;
    repeat (8) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    t_reset;
    idle(4);
    t_ref;
    t_res;
    t_abort;
    t_mon;
    t_other;
    end_of_test;
  end
endmodule // test_dac_ref_monitor_spi_ctrl
